/* File: design/rtr_core.sv */
// Purpose: Remote reading registers, offset correction and high setpoint storage.
// Assumes: Converter delivers one result with a one-cycle valid pulse.
// Notes:   Registers sit on a byte-wide strobe port; read data follows one cycle later.
//
// Our own choice: strobed register access.

`timescale 1ns/10ps
`default_nettype none

module rtr_core
   import rtr_pkg::*;
(
   input  wire logic                           i_core_clk,
   input  wire logic                           i_sys_rst,
   input  wire logic [rtr_pkg::ADDR_W-1:0]     i_addr,
   input  wire logic [rtr_pkg::DATA_W-1:0]     i_wdata,
   input  wire logic                           i_wr,
   input  wire logic                           i_rd,
   output logic      [rtr_pkg::DATA_W-1:0]     o_rdata,
   input  wire logic [rtr_pkg::READING_W-1:0]  i_adc_result,
   input  wire logic                           i_adc_valid,
   output logic      [rtr_pkg::READING_W-1:0]  o_signed_reading,
   output logic      [rtr_pkg::SUM_W-1:0]      o_high_limit,
   output logic                                o_high_exceeded,
   output logic                                o_filter_en,
   output logic                                o_unsigned_format_select
);
   import rtr_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [DATA_W-1:0]     offset_upper_bits_q;
   logic [FRAC_W-1:0]     offset_lower_bits_q;
   logic [DATA_W-1:0]     high_limit_upper_bits_q;
   logic [FRAC_W-1:0]     high_limit_lower_bits_q;
   logic [DATA_W-1:0]     config_q;
   logic [READING_W-1:0]  unsigned_q;
   logic [READING_W-1:0]  signed_q;
   logic [SUM_W-1:0]      sum_q;
   logic                  valid_seen_q;
   logic                  high_exceeded_q;
   logic [DATA_W-1:0]     lower_shadow_q;
   logic [DATA_W-1:0]     rdata_q;
   logic [DATA_W-1:0]     rdata_d;

   logic [SETPOINT_W-1:0] offset_full;
   logic [SETPOINT_W-1:0] limit_full;
   logic [SUM_W-1:0]      sum_now;
   logic [READING_W-1:0]  unsigned_now;
   logic [READING_W-1:0]  signed_now;
   logic [SUM_W-1:0]      limit_ext;
   logic [DATA_W-1:0]     unsigned_upper_byte;
   logic [DATA_W-1:0]     unsigned_lower_byte;
   logic [FILT_W-1:0]     unsigned_reading_filter_fraction;
   logic                  filter_en;
   logic                  unsigned_format_select;

   assign filter_en   = config_q[CFG_FILTER_BIT];
   assign unsigned_format_select         = config_q[CFG_USF_BIT];
   assign offset_full = {offset_upper_bits_q, offset_lower_bits_q};
   assign limit_full  = {high_limit_upper_bits_q, high_limit_lower_bits_q};

   // ****************************************************************
   // Offset correction and setpoint format
   // ****************************************************************
   rtr_offset_add u_offset_add (
      .i_adc      (i_adc_result),
      .i_offset   (offset_full),
      .o_sum      (sum_now),
      .o_unsigned (unsigned_now),
      .o_signed   (signed_now)
   );

   rtr_limit_fmt u_limit_fmt (
      .i_limit                  (limit_full),
      .i_unsigned_format_select (unsigned_format_select),
      .o_limit                  (limit_ext)
   );

   // ****************************************************************
   // Software registers
   // ****************************************************************
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         offset_upper_bits_q <= RST_OFFSET;
         offset_lower_bits_q <= RST_OFFSET[DATA_W-1:FRAC_LSB];
      end else if (i_wr && (i_addr == ADDR_OFFSET_UPPER)) begin
         offset_upper_bits_q <= i_wdata;
      end else if (i_wr && (i_addr == ADDR_OFFSET_LOWER)) begin
         // Only the three fraction bits are kept
         offset_lower_bits_q <= i_wdata[DATA_W-1:FRAC_LSB];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         high_limit_upper_bits_q <= RST_HIGH_UPPER;
         high_limit_lower_bits_q <= RST_HIGH_LOWER[DATA_W-1:FRAC_LSB];
      end else if (i_wr && (i_addr == ADDR_HIGH_UPPER)) begin
         high_limit_upper_bits_q <= i_wdata;
      end else if (i_wr && (i_addr == ADDR_HIGH_LOWER)) begin
         high_limit_lower_bits_q <= i_wdata[DATA_W-1:FRAC_LSB];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         config_q <= RST_CONFIG;
      end else if (i_wr && (i_addr == ADDR_ENH_CONFIG)) begin
         config_q <= i_wdata;
      end
   end

   // ****************************************************************
   // Conversion results
   // ****************************************************************
   // Results refresh only on a valid pulse so a read never sees a half-updated sum
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         unsigned_q   <= '0;
         signed_q     <= '0;
         sum_q        <= '0;
         valid_seen_q <= 1'b0;
      end else if (i_adc_valid) begin
         unsigned_q   <= unsigned_now;
         signed_q     <= signed_now;
         sum_q        <= sum_now;
         valid_seen_q <= 1'b1;
      end
   end

   // Compare uses the live setpoint so a new limit acts without waiting for a result
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         high_exceeded_q <= 1'b0;
      end else begin
         high_exceeded_q <= valid_seen_q && ($signed(sum_q) > $signed(limit_ext));
      end
   end

   // ****************************************************************
   // Unsigned reading bytes
   // ****************************************************************
   assign unsigned_reading_filter_fraction = filter_en ?
                                             unsigned_q[FILT_W-1:0] :
                                             '0;
   assign unsigned_upper_byte = unsigned_q[READING_W-1:FRAC_W+FILT_W];
   assign unsigned_lower_byte = {unsigned_q[FRAC_W+FILT_W-1:FILT_W],
                                 unsigned_reading_filter_fraction,
                                 3'b000};

   // Lower byte is frozen when the upper byte is read; host must read upper first
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         lower_shadow_q <= READ_ZERO;
      end else if (i_rd && (i_addr == ADDR_UNSIGNED_UPPER)) begin
         lower_shadow_q <= unsigned_lower_byte;
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   always_comb begin
      rdata_d = READ_ZERO;
      if (i_rd) begin
         unique case (i_addr)
            ADDR_HIGH_UPPER:     rdata_d = high_limit_upper_bits_q;
            ADDR_HIGH_LOWER:     rdata_d = {high_limit_lower_bits_q, 5'b00000};
            ADDR_OFFSET_UPPER:   rdata_d = offset_upper_bits_q;
            ADDR_OFFSET_LOWER:   rdata_d = {offset_lower_bits_q, 5'b00000};
            ADDR_UNSIGNED_UPPER: rdata_d = unsigned_upper_byte;
            ADDR_UNSIGNED_LOWER: rdata_d = lower_shadow_q;
            ADDR_ENH_CONFIG:     rdata_d = config_q;
            ADDR_STATUS: begin
               rdata_d[STAT_HIGH_BIT]  = high_exceeded_q;
               rdata_d[STAT_VALID_BIT] = valid_seen_q;
            end
            default:             rdata_d = READ_ZERO;
         endcase
      end
   end

   // Data stands only in the cycle after the strobe, zero otherwise
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rdata_q <= READ_ZERO;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign o_rdata                  = rdata_q;
   assign o_signed_reading         = signed_q;
   assign o_high_limit             = limit_ext;
   assign o_high_exceeded          = high_exceeded_q;
   assign o_filter_en              = filter_en;
   assign o_unsigned_format_select = unsigned_format_select;

endmodule

`default_nettype wire

/* File: design/rtr_pkg.sv */
// Purpose: Constants for the remote temperature result, offset and setpoint block.
// Assumes: One core clock, synchronous active-high reset, byte-wide register port.
// Notes:   Readings are kept in 1/32 degree units; setpoint and offset in 1/8 degree units.

package rtr_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int          ADDR_W              = 8;
   localparam int          DATA_W              = 8;
   localparam logic [7:0]  ADDR_HIGH_UPPER     = 8'h07;
   localparam logic [7:0]  ADDR_OFFSET_UPPER   = 8'h11;
   localparam logic [7:0]  ADDR_OFFSET_LOWER   = 8'h12;
   localparam logic [7:0]  ADDR_HIGH_LOWER     = 8'h13;
   localparam logic [7:0]  ADDR_UNSIGNED_UPPER = 8'h31;
   localparam logic [7:0]  ADDR_UNSIGNED_LOWER = 8'h32;
   localparam logic [7:0]  ADDR_ENH_CONFIG     = 8'h50;
   localparam logic [7:0]  ADDR_STATUS         = 8'h51;

   // ****************************************************************
   // Field layout
   // ****************************************************************
   localparam int          FRAC_LSB            = 5;
   localparam int          FRAC_W              = 3;
   localparam int          FILT_LSB            = 3;
   localparam int          FILT_W              = 2;
   localparam int          CFG_FILTER_BIT      = 0;
   localparam int          CFG_USF_BIT         = 3;
   localparam int          STAT_HIGH_BIT       = 0;
   localparam int          STAT_VALID_BIT      = 1;

   // ****************************************************************
   // Widths and reset values
   // ****************************************************************
   localparam int          READING_W           = 13;
   localparam int          SETPOINT_W          = 11;
   localparam int          SUM_W               = 15;
   localparam logic [7:0]  RST_HIGH_UPPER      = 8'h69;
   localparam logic [7:0]  RST_HIGH_LOWER      = 8'h00;
   localparam logic [7:0]  RST_OFFSET          = 8'h00;
   localparam logic [7:0]  RST_CONFIG          = 8'h00;
   localparam logic [7:0]  READ_ZERO           = 8'h00;

endpackage

/* File: design/rtr_offset_add.sv */
// Purpose: Adds the offset to the converter result and saturates both reading formats.
// Assumes: Converter result is unsigned in 1/32 degree units.
// Notes:   Purely combinational; the caller registers the outputs.

`timescale 1ns/10ps
`default_nettype none

module rtr_offset_add
   import rtr_pkg::*;
(
   input  wire logic [rtr_pkg::READING_W-1:0]  i_adc,
   input  wire logic [rtr_pkg::SETPOINT_W-1:0] i_offset,
   output logic      [rtr_pkg::SUM_W-1:0]      o_sum,
   output logic      [rtr_pkg::READING_W-1:0]  o_unsigned,
   output logic      [rtr_pkg::READING_W-1:0]  o_signed
);
   import rtr_pkg::*;

   logic [SUM_W-1:0] adc_ext;
   logic [SUM_W-1:0] off_ext;

   assign adc_ext = {2'b00, i_adc};
   // Offset step is 1/8 degree, so shift into 1/32 units and sign-extend
   assign off_ext = {{2{i_offset[SETPOINT_W-1]}}, i_offset, 2'b00};
   assign o_sum   = adc_ext + off_ext;

   // Negative sums clamp to zero rather than wrapping to a huge value
   always_comb begin
      if (o_sum[SUM_W-1]) begin
         o_unsigned = '0;
      end else if (o_sum[SUM_W-2:READING_W] != '0) begin
         o_unsigned = '1;
      end else begin
         o_unsigned = o_sum[READING_W-1:0];
      end
   end

   // Signed format tops out just under 128 degrees
   always_comb begin
      // Sign and guard bits must all agree for the sum to fit
      if (o_sum[SUM_W-1] && (o_sum[SUM_W-2:READING_W-1] != '1)) begin
         o_signed = {1'b1, {(READING_W-1){1'b0}}};
      end else if (!o_sum[SUM_W-1] && (o_sum[SUM_W-2:READING_W-1] != '0)) begin
         o_signed = {1'b0, {(READING_W-1){1'b1}}};
      end else begin
         o_signed = o_sum[READING_W-1:0];
      end
   end

endmodule

`default_nettype wire

/* File: design/rtr_limit_fmt.sv */
// Purpose: Expands the 11-bit high setpoint into the common signed 1/32 degree scale.
// Assumes: Setpoint step is 1/8 degree in both formats.
// Notes:   Combinational; the selector comes from the configuration register.

`timescale 1ns/10ps
`default_nettype none

module rtr_limit_fmt
   import rtr_pkg::*;
(
   input  wire logic [rtr_pkg::SETPOINT_W-1:0] i_limit,
   input  wire logic                           i_unsigned_format_select,
   output logic      [rtr_pkg::SUM_W-1:0]      o_limit
);
   import rtr_pkg::*;

   always_comb begin
      if (i_unsigned_format_select) begin
         o_limit = {2'b00, i_limit, 2'b00};
      end else begin
         o_limit = {{2{i_limit[SETPOINT_W-1]}}, i_limit, 2'b00};
      end
   end

endmodule

`default_nettype wire

/* File: tb/rtr_core_assertions.sv */
// Purpose: Port-level checks for the remote reading block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Sees only the top-level ports.
`timescale 1ns/10ps
`default_nettype none
module rtr_core_chk
   import rtr_pkg::*;
(
   input wire logic                          i_core_clk,
   input wire logic                          i_sys_rst,
   input wire logic [rtr_pkg::ADDR_W-1:0]    i_addr,
   input wire logic [rtr_pkg::DATA_W-1:0]    i_wdata,
   input wire logic                          i_wr,
   input wire logic                          i_rd,
   input wire logic [rtr_pkg::DATA_W-1:0]    o_rdata,
   input wire logic [rtr_pkg::READING_W-1:0] i_adc_result,
   input wire logic                          i_adc_valid,
   input wire logic [rtr_pkg::READING_W-1:0] o_signed_reading,
   input wire logic [rtr_pkg::SUM_W-1:0]     o_high_limit,
   input wire logic                          o_high_exceeded,
   input wire logic                          o_filter_en,
   input wire logic                          o_unsigned_format_select
);
   // ****************************************************************
   // Register and output checks
   // ****************************************************************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   sequence s_rd(logic [7:0] a);
      i_rd && (i_addr == a);
   endsequence
   // Reserved bits masked on the read data cycle
   property p_rd_mask(logic [7:0] a, logic [7:0] m);
      s_rd(a) |=> ((o_rdata & m) == 8'h00);
   endproperty
   chk_lower_resv_zero: assert property (p_rd_mask(ADDR_UNSIGNED_LOWER, 8'h07))
      else $error("reserved reading bits not zero");
   chk_offlo_resv_zero: assert property (p_rd_mask(ADDR_OFFSET_LOWER, 8'h1f))
      else $error("reserved offset bits not zero");
   chk_limlo_resv_zero: assert property (p_rd_mask(ADDR_HIGH_LOWER, 8'h1f))
      else $error("reserved setpoint bits not zero");
   chk_filter_off_zero: assert property (
      (!o_filter_en && i_rd && (i_addr == ADDR_UNSIGNED_LOWER)) |=> (o_rdata[4:3] == 2'b00))
      else $error("extra fraction bits set with filter off");
   chk_signed_hold: assert property (!i_adc_valid |=> $stable(o_signed_reading))
      else $error("signed reading moved without a result");
   chk_cfg_bits_follow: assert property (
      (i_wr && (i_addr == ADDR_ENH_CONFIG)) |=>
         ((o_filter_en == $past(i_wdata[CFG_FILTER_BIT]))
         && (o_unsigned_format_select == $past(i_wdata[CFG_USF_BIT]))))
      else $error("config bits not taken from write");
   chk_unsigned_limit: assert property (
      o_unsigned_format_select |-> (o_high_limit[14:13] == 2'b00))
      else $error("unsigned setpoint went negative");
   chk_signed_limit: assert property (
      !o_unsigned_format_select |-> (o_high_limit[14] == o_high_limit[13]))
      else $error("signed setpoint out of range");
   chk_limit_step: assert property (o_high_limit[1:0] == 2'b00)
      else $error("setpoint finer than eighth degree");
endmodule
bind rtr_core rtr_core_chk i_chk (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_adc_result(i_adc_result), .i_adc_valid(i_adc_valid),
   .o_signed_reading(o_signed_reading), .o_high_limit(o_high_limit),
   .o_high_exceeded(o_high_exceeded), .o_filter_en(o_filter_en),
   .o_unsigned_format_select(o_unsigned_format_select));
`default_nettype wire

/* File: tb/rtr_host.sv */
// Purpose: Management host model driving the register port.
// Assumes: Tasks entered in the time step of a rising edge.
// Notes:   Released write data and read address show inverted values.
`timescale 1ns/10ps
`default_nettype none
module rtr_host
   import rtr_pkg::*;
(
   input  wire logic                       i_core_clk,
   input  wire logic [rtr_pkg::DATA_W-1:0] i_rdata,
   output var  logic [rtr_pkg::ADDR_W-1:0] o_addr,
   output var  logic [rtr_pkg::DATA_W-1:0] o_wdata,
   output var  logic                       o_wr,
   output var  logic                       o_rd
);
   initial begin
      o_addr = 8'h00;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_core_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
      // One idle edge so the next strobe is never assigned in this step
      @(posedge i_core_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_core_clk);
      o_rd <= 1'b0;
      o_addr <= ~a;
      // Data stands between these two edges; taken before it clears
      @(posedge i_core_clk);
      d = i_rdata;
   endtask
   // Upper byte first so the lower byte matches it
   task automatic rd_result(output logic [7:0] up, output logic [7:0] lo);
      rd(ADDR_UNSIGNED_UPPER, up);
      rd(ADDR_UNSIGNED_LOWER, lo);
   endtask
endmodule
`default_nettype wire

/* File: tb/rtr_core_tb_top.sv */
// Purpose: Self-checking bench for the remote reading block.
// Assumes: Host model on the register port, bench drives the converter.
// Notes:   Expected values are worked out from the field weights.
`timescale 1ns/10ps
`default_nettype none
module rtr_core_tb_top;
   import rtr_pkg::*;
   logic                 i_core_clk   = 1'b0;
   logic                 i_sys_rst    = 1'b1;
   logic [ADDR_W-1:0]    i_addr;
   logic [DATA_W-1:0]    i_wdata;
   logic                 i_wr;
   logic                 i_rd;
   logic [DATA_W-1:0]    o_rdata;
   logic [READING_W-1:0] i_adc_result = '0;
   logic                 i_adc_valid  = 1'b0;
   logic [READING_W-1:0] o_signed_reading;
   logic [SUM_W-1:0]     o_high_limit;
   logic                 o_high_exceeded;
   logic                 o_filter_en;
   logic                 o_unsigned_format_select;
   int                   fail_count   = 0;
   int                   checks_done  = 0;
   always #5 i_core_clk = ~i_core_clk;
   rtr_host i_host (.i_core_clk(i_core_clk), .i_rdata(o_rdata), .o_addr(i_addr),
      .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
   rtr_core i_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_adc_result(i_adc_result), .i_adc_valid(i_adc_valid),
      .o_signed_reading(o_signed_reading), .o_high_limit(o_high_limit),
      .o_high_exceeded(o_high_exceeded), .o_filter_en(o_filter_en),
      .o_unsigned_format_select(o_unsigned_format_select));
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      i_host.rd(a, d);
      check(16'(d), 16'(e));
   endtask
   task automatic conv(input logic [12:0] r);
      i_adc_result <= r;
      i_adc_valid <= 1'b1;
      @(posedge i_core_clk);
      i_adc_valid <= 1'b0;
      @(posedge i_core_clk);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      rdc(ADDR_HIGH_UPPER, 8'h69);
      rdc(ADDR_HIGH_LOWER, 8'h00);
      rdc(ADDR_OFFSET_UPPER, 8'h00);
      rdc(ADDR_OFFSET_LOWER, 8'h00);
      rdc(8'h20, 8'h00);
      rdc(ADDR_STATUS, 8'h00);
      check(16'(o_high_limit), 16'd3360);
      $display("test reset done");
   endtask
   task automatic t_regs();
      i_host.wr(ADDR_OFFSET_LOWER, 8'hff);
      rdc(ADDR_OFFSET_LOWER, 8'he0);
      i_host.wr(ADDR_HIGH_LOWER, 8'hff);
      rdc(ADDR_HIGH_LOWER, 8'he0);
      i_host.wr(ADDR_HIGH_UPPER, 8'hc0);
      check(16'(o_high_limit), 16'h781c);
      i_host.wr(ADDR_ENH_CONFIG, 8'h08);
      check(16'(o_high_limit), 16'h181c);
      rdc(ADDR_ENH_CONFIG, 8'h08);
      i_host.wr(ADDR_ENH_CONFIG, 8'h00);
      i_host.wr(ADDR_HIGH_UPPER, 8'h69);
      i_host.wr(ADDR_HIGH_LOWER, 8'h00);
      i_host.wr(ADDR_OFFSET_LOWER, 8'h00);
      $display("test registers done");
   endtask
   task automatic t_unsigned();
      logic [12:0] r;
      logic [7:0]  up;
      logic [7:0]  lo;
      for (int f = 0; f < 2; f++) begin
         i_host.wr(ADDR_ENH_CONFIG, {7'h00, f[0]});
         r = 13'h1abe ^ 13'(f);
         conv(r);
         i_host.rd_result(up, lo);
         check(16'(up), 16'(r[12:5]));
         check(16'(lo), {8'h00, r[4:2], f[0] ? r[1:0] : 2'b00, 3'b000});
      end
      // New result between the two reads must not leak in
      i_host.rd(ADDR_UNSIGNED_UPPER, up);
      conv(13'h0002);
      rdc(ADDR_UNSIGNED_LOWER, {r[4:0], 3'b000});
      i_host.wr(ADDR_ENH_CONFIG, 8'h00);
      $display("test unsigned done");
   endtask
   task automatic t_offset();
      i_host.wr(ADDR_OFFSET_UPPER, 8'hfd);
      i_host.wr(ADDR_OFFSET_LOWER, 8'h80);
      conv(13'h0640);
      check(16'(o_signed_reading), 16'd1520);
      conv(13'h0010);
      check(16'(o_signed_reading), 16'h1fc0);
      conv(13'd3400);
      @(posedge i_core_clk);
      check(16'(o_high_exceeded), 16'h0000);
      i_host.wr(ADDR_OFFSET_UPPER, 8'h00);
      i_host.wr(ADDR_OFFSET_LOWER, 8'h00);
      conv(13'd3400);
      @(posedge i_core_clk);
      check(16'(o_high_exceeded), 16'h0001);
      rdc(ADDR_STATUS, 8'h03);
      conv(13'h1900);
      check(16'(o_signed_reading), 16'h0fff);
      $display("test offset done");
   endtask
   initial begin
      repeat (4) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      t_reset();
      t_regs();
      t_unsigned();
      t_offset();
      finish_test();
   end
   // Whole run is under a hundred cycles
   initial begin
      #20000;
      fail_count++;
      finish_test();
   end
endmodule
`default_nettype wire
